// file: logic/rrt_exec.sv
// Functional notes
// - B-to-accumulator copy loads A from B, B unchanged.
// - accumulator-to-B copy writes A into B, A unchanged.
// - row-to-accumulator copy loads A from Y.
// - accumulator-to-row copy writes A into Y.
// - pack puts B in E upper nibble, A in lower nibble.
// - unpack copies E upper nibble to B, lower nibble to A.
// - accumulator-to-D writes A bits 2..0 into D.
// - stack pointer read: A = {0, stack pointer}.
// - load row column loads X and Y from immediates.
// - load file group writes 2-bit immediate into Z.
// - row decrement subtracts one from Y modulo sixteen.
// - memory load: A from addressed nibble, X ^= immediate.
// - exchange swaps A with addressed nibble, X ^= immediate.
// - exchange-decrement also decrements Y.
// - exchange-increment also increments Y modulo sixteen.
// - memory store writes A to addressed nibble, X ^= immediate.
// - after Y increment, skip next instruction when Y becomes zero.
// - after Y decrement, skip next instruction when Y becomes fifteen.
// - consecutive load row column: only first executes, rest skipped.
module rrt_exec (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_valid,
   input wire logic [9:0] i_word,
   input wire logic [2:0] i_stack_pointer,
   input wire logic [3:0] i_mem_rdata,
   output rrt_pkg::rrt_regs_t o_regs,
   output rrt_pkg::rrt_mem_t o_mem,
   output logic o_mem_en,
   output logic o_skip,
   output logic o_carry_we
);
   // ====================================================================
   // decode
   rrt_pkg::rrt_op_t op;
   logic [3:0] imm_j;
   logic [3:0] imm_x;
   logic [3:0] imm_y;
   logic [1:0] imm_z;

   rrt_decode u_dec (
      .i_word(i_word),
      .o_op(op),
      .o_imm_j(imm_j),
      .o_imm_x(imm_x),
      .o_imm_y(imm_y),
      .o_imm_z(imm_z)
   );

   // ====================================================================
   // state
   rrt_pkg::rrt_regs_t regs_r;
   rrt_pkg::rrt_regs_t regs_nxt;
   logic skip_r;
   logic skip_nxt;
   logic lrc_last_r;
   logic lrc_last_nxt;
   logic exec;
   logic [3:0] y_inc;
   logic [3:0] y_dec;

   // a skipped word is consumed but leaves the registers and memory unchanged
   assign exec = i_valid && !skip_r;
   assign y_inc = regs_r.y + 4'h1;
   assign y_dec = regs_r.y - 4'h1;

   // ====================================================================
   // execute, one word per cycle
   always_comb begin
      regs_nxt = regs_r;
      skip_nxt = skip_r;
      lrc_last_nxt = lrc_last_r;
      if (i_valid) begin
         skip_nxt = 1'b0;
         // run tracking follows fetched words, skipped ones included
         lrc_last_nxt = (op == rrt_pkg::OP_LRC);
         if (op == rrt_pkg::OP_LRC && lrc_last_r) begin
            skip_nxt = 1'b0;
         end
      end
      if (exec) begin
         unique case (op)
            rrt_pkg::OP_B_TO_ACC: regs_nxt.acc = regs_r.b;
            rrt_pkg::OP_ACC_TO_B: regs_nxt.b = regs_r.acc;
            rrt_pkg::OP_RY: regs_nxt.acc = regs_r.y;
            rrt_pkg::OP_WY: regs_nxt.y = regs_r.acc;
            rrt_pkg::OP_PACK: regs_nxt.e = {regs_r.b, regs_r.acc};
            rrt_pkg::OP_UNPACK: begin
               regs_nxt.b = regs_r.e[7:4];
               regs_nxt.acc = regs_r.e[3:0];
            end
            rrt_pkg::OP_WD: regs_nxt.d = regs_r.acc[2:0];
            rrt_pkg::OP_RX: regs_nxt.acc = regs_r.x;
            rrt_pkg::OP_RSP: regs_nxt.acc = {1'b0, i_stack_pointer};
            rrt_pkg::OP_LRC: begin
               regs_nxt.x = imm_x;
               regs_nxt.y = imm_y;
            end
            rrt_pkg::OP_LFG: regs_nxt.z = imm_z;
            rrt_pkg::OP_INC: begin
               regs_nxt.y = y_inc;
               skip_nxt = (y_inc == rrt_pkg::ROW_INC_SKIP_VAL);
            end
            rrt_pkg::OP_DEC: begin
               regs_nxt.y = y_dec;
               skip_nxt = (y_dec == rrt_pkg::ROW_DEC_SKIP_VAL);
            end
            rrt_pkg::OP_LDM: begin
               regs_nxt.acc = i_mem_rdata;
               regs_nxt.x = regs_r.x ^ imm_j;
            end
            rrt_pkg::OP_XCH: begin
               regs_nxt.acc = i_mem_rdata;
               regs_nxt.x = regs_r.x ^ imm_j;
            end
            rrt_pkg::OP_XCHD: begin
               regs_nxt.acc = i_mem_rdata;
               regs_nxt.x = regs_r.x ^ imm_j;
               regs_nxt.y = y_dec;
               skip_nxt = (y_dec == rrt_pkg::ROW_DEC_SKIP_VAL);
            end
            rrt_pkg::OP_XCHI: begin
               regs_nxt.acc = i_mem_rdata;
               regs_nxt.x = regs_r.x ^ imm_j;
               regs_nxt.y = y_inc;
               skip_nxt = (y_inc == rrt_pkg::ROW_INC_SKIP_VAL);
            end
            rrt_pkg::OP_STM: regs_nxt.x = regs_r.x ^ imm_j;
            default: regs_nxt = regs_r;
         endcase
      end
      // a load following a load in the same run never executes
      if (i_valid && op == rrt_pkg::OP_LRC && lrc_last_r) begin
         regs_nxt.x = regs_r.x;
         regs_nxt.y = regs_r.y;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         regs_r <= '{acc: rrt_pkg::RST_NIB, b: rrt_pkg::RST_NIB, e: rrt_pkg::RST_E,
                     d: rrt_pkg::RST_D, x: rrt_pkg::RST_NIB, y: rrt_pkg::RST_NIB,
                     z: rrt_pkg::RST_Z};
         skip_r <= 1'b0;
         lrc_last_r <= 1'b0;
      end else begin
         regs_r <= regs_nxt;
         skip_r <= skip_nxt;
         lrc_last_r <= lrc_last_nxt;
      end
   end

   // ====================================================================
   // memory port, write is combinational with the executing word
   always_comb begin
      o_mem.wr = exec && (op == rrt_pkg::OP_STM || op == rrt_pkg::OP_XCH ||
                          op == rrt_pkg::OP_XCHD || op == rrt_pkg::OP_XCHI);
      o_mem.z = regs_r.z;
      o_mem.x = regs_r.x;
      o_mem.y = regs_r.y;
      o_mem.wdata = regs_r.acc;
      o_mem_en = exec && (o_mem.wr || op == rrt_pkg::OP_LDM);
   end

   assign o_regs = regs_r;
   assign o_skip = skip_r;
   // carry is never written by this group
   assign o_carry_we = 1'b0;
endmodule

// file: logic/rrt_pkg.sv
package rrt_pkg;
   // ====================================================================
   // opcode patterns, 10-bit program word
   localparam int unsigned WORD_W = 10;
   localparam logic [9:0] OP_COPY_B_TO_ACC = 10'h01E;
   localparam logic [9:0] OP_COPY_ACC_TO_B = 10'h00E;
   localparam logic [9:0] OP_COPY_ROW_TO_ACC = 10'h01F;
   localparam logic [9:0] OP_COPY_ACC_TO_ROW = 10'h00C;
   localparam logic [9:0] OP_PACK_PAIR_INTO_E = 10'h01A;
   localparam logic [9:0] OP_UNPACK_E_INTO_PAIR = 10'h02A;
   localparam logic [9:0] OP_COPY_ACC_TO_D = 10'h029;
   localparam logic [9:0] OP_COPY_COLUMN_TO_ACC = 10'h052;
   localparam logic [9:0] OP_READ_STACK_POINTER = 10'h050;
   localparam logic [9:0] OP_ROW_INCREMENT = 10'h013;
   localparam logic [9:0] OP_ROW_DECREMENT = 10'h017;
   // upper bits of opcodes carrying immediates
   localparam logic [1:0] PFX_LOAD_ROW_COLUMN = 2'h3;
   localparam logic [7:0] PFX_LOAD_FILE_GROUP = 8'h12;
   localparam logic [5:0] PFX_LOAD_ACC_FROM_MEM = 6'h2C;
   localparam logic [5:0] PFX_SWAP_ACC_MEM = 6'h2D;
   localparam logic [5:0] PFX_SWAP_ACC_MEM_DEC = 6'h2F;
   localparam logic [5:0] PFX_SWAP_ACC_MEM_INC = 6'h2E;
   localparam logic [5:0] PFX_STORE_ACC_TO_MEM = 6'h2B;
   // skip thresholds for row updates
   localparam logic [3:0] ROW_INC_SKIP_VAL = 4'h0;
   localparam logic [3:0] ROW_DEC_SKIP_VAL = 4'hF;
   // reset values
   localparam logic [3:0] RST_NIB = 4'h0;
   localparam logic [7:0] RST_E = 8'h00;
   localparam logic [2:0] RST_D = 3'h0;
   localparam logic [1:0] RST_Z = 2'h0;

   typedef enum {
      OP_NONE, OP_ACC_TO_B, OP_B_TO_ACC, OP_RY, OP_WY, OP_PACK, OP_UNPACK, OP_WD, OP_RX,
      OP_RSP, OP_LRC, OP_LFG, OP_INC, OP_DEC, OP_LDM, OP_XCH, OP_XCHD, OP_XCHI, OP_STM
   } rrt_op_t;

   // register file snapshot
   typedef struct packed {
      logic [3:0] acc;
      logic [3:0] b;
      logic [7:0] e;
      logic [2:0] d;
      logic [3:0] x;
      logic [3:0] y;
      logic [1:0] z;
   } rrt_regs_t;

   // memory request for the addressed nibble
   typedef struct packed {
      logic wr;
      logic [1:0] z;
      logic [3:0] x;
      logic [3:0] y;
      logic [3:0] wdata;
   } rrt_mem_t;
endpackage

// file: logic/rrt_decode.sv
module rrt_decode (
   input wire logic [9:0] i_word,
   output rrt_pkg::rrt_op_t o_op,
   output logic [3:0] o_imm_j,
   output logic [3:0] o_imm_x,
   output logic [3:0] o_imm_y,
   output logic [1:0] o_imm_z
);
   // ====================================================================
   // immediate fields
   assign o_imm_j = i_word[3:0];
   assign o_imm_x = i_word[7:4];
   assign o_imm_y = i_word[3:0];
   assign o_imm_z = i_word[1:0];

   // ====================================================================
   // opcode match
   always_comb begin
      o_op = rrt_pkg::OP_NONE;
      if (i_word[9:8] == rrt_pkg::PFX_LOAD_ROW_COLUMN) begin
         o_op = rrt_pkg::OP_LRC;
      end else if (i_word[9:4] == rrt_pkg::PFX_LOAD_ACC_FROM_MEM) begin
         o_op = rrt_pkg::OP_LDM;
      end else if (i_word[9:4] == rrt_pkg::PFX_SWAP_ACC_MEM) begin
         o_op = rrt_pkg::OP_XCH;
      end else if (i_word[9:4] == rrt_pkg::PFX_SWAP_ACC_MEM_DEC) begin
         o_op = rrt_pkg::OP_XCHD;
      end else if (i_word[9:4] == rrt_pkg::PFX_SWAP_ACC_MEM_INC) begin
         o_op = rrt_pkg::OP_XCHI;
      end else if (i_word[9:4] == rrt_pkg::PFX_STORE_ACC_TO_MEM) begin
         o_op = rrt_pkg::OP_STM;
      end else if (i_word[9:2] == rrt_pkg::PFX_LOAD_FILE_GROUP) begin
         o_op = rrt_pkg::OP_LFG;
      end else begin
         unique case (i_word)
            rrt_pkg::OP_COPY_B_TO_ACC: o_op = rrt_pkg::OP_B_TO_ACC;
            rrt_pkg::OP_COPY_ACC_TO_B: o_op = rrt_pkg::OP_ACC_TO_B;
            rrt_pkg::OP_COPY_ROW_TO_ACC: o_op = rrt_pkg::OP_RY;
            rrt_pkg::OP_COPY_ACC_TO_ROW: o_op = rrt_pkg::OP_WY;
            rrt_pkg::OP_PACK_PAIR_INTO_E: o_op = rrt_pkg::OP_PACK;
            rrt_pkg::OP_UNPACK_E_INTO_PAIR: o_op = rrt_pkg::OP_UNPACK;
            rrt_pkg::OP_COPY_ACC_TO_D: o_op = rrt_pkg::OP_WD;
            rrt_pkg::OP_COPY_COLUMN_TO_ACC: o_op = rrt_pkg::OP_RX;
            rrt_pkg::OP_READ_STACK_POINTER: o_op = rrt_pkg::OP_RSP;
            rrt_pkg::OP_ROW_INCREMENT: o_op = rrt_pkg::OP_INC;
            rrt_pkg::OP_ROW_DECREMENT: o_op = rrt_pkg::OP_DEC;
            default: o_op = rrt_pkg::OP_NONE;
         endcase
      end
   end
endmodule

// file: dv/rrt_exec_monitor.sv
module rrt_exec_monitor (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_valid,
   input wire logic [9:0] i_word,
   input wire logic [2:0] i_stack_pointer,
   input wire logic [3:0] i_mem_rdata,
   input wire rrt_pkg::rrt_regs_t o_regs,
   input wire rrt_pkg::rrt_mem_t o_mem,
   input wire logic o_mem_en,
   input wire logic o_skip,
   input wire logic o_carry_we
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // ==================================================================
   // decode helpers
   logic prev_lrc_r;
   wire ex = i_valid && !o_skip;
   wire lrc = i_word[9:8] == rrt_pkg::PFX_LOAD_ROW_COLUMN;
   wire [3:0] lo = i_word[3:0];
   wire [3:0] hi = i_word[7:4];
   wire b2a = ex && i_word == rrt_pkg::OP_COPY_B_TO_ACC;
   wire rsp = ex && i_word == rrt_pkg::OP_READ_STACK_POINTER;
   wire inc = ex && i_word == rrt_pkg::OP_ROW_INCREMENT;
   wire dec = ex && i_word == rrt_pkg::OP_ROW_DECREMENT;
   wire ldm = ex && i_word[9:4] == rrt_pkg::PFX_LOAD_ACC_FROM_MEM;
   wire stm = ex && i_word[9:4] == rrt_pkg::PFX_STORE_ACC_TO_MEM;
   // run tracked over every fetched word, skipped ones too
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn)
         prev_lrc_r <= 1'b0;
      else if (i_valid)
         prev_lrc_r <= lrc;
   // ==================================================================
   // properties
   property p_b2a; b2a |=> o_regs.acc == $past(o_regs.b) && $stable(o_regs.b); endproperty
   a_b2a: assert property (p_b2a) else $error("b to acc copy wrong");
   property p_rsp; rsp |=> o_regs.acc == {1'b0, $past(i_stack_pointer)}; endproperty
   a_rsp: assert property (p_rsp) else $error("stack pointer read wrong");
   property p_lrc; ex && lrc && !prev_lrc_r |=> o_regs.x == $past(hi) && o_regs.y == $past(lo);
   endproperty
   a_lrc: assert property (p_lrc) else $error("row column load wrong");
   property p_run; i_valid && lrc && prev_lrc_r |=> $stable(o_regs.x) && $stable(o_regs.y);
   endproperty
   a_run: assert property (p_run) else $error("repeated row column load ran");
   property p_ldm; ldm |=> o_regs.acc == $past(i_mem_rdata) && o_regs.x == ($past(o_regs.x) ^ $past(lo));
   endproperty
   a_ldm: assert property (p_ldm) else $error("memory load wrong");
   property p_stm; stm |-> o_mem_en && o_mem.wr && o_mem.wdata == o_regs.acc; endproperty
   a_stm: assert property (p_stm) else $error("memory store wrong");
   property p_inc; inc |=> o_regs.y == $past(o_regs.y) + 4'h1 && o_skip == (o_regs.y == 4'h0);
   endproperty
   a_inc: assert property (p_inc) else $error("row increment wrong");
   property p_dec; dec |=> o_regs.y == $past(o_regs.y) - 4'h1 && o_skip == (o_regs.y == 4'hF);
   endproperty
   a_dec: assert property (p_dec) else $error("row decrement wrong");
   property p_cy; o_carry_we == 1'b0; endproperty
   a_cy: assert property (p_cy) else $error("carry written");
   c_inc_skip: cover property (inc ##1 o_skip);
   c_dec_skip: cover property (dec ##1 o_skip);
   c_run: cover property (i_valid && lrc && prev_lrc_r);
endmodule

bind rrt_exec rrt_exec_monitor rrt_exec_monitor_inst (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_valid(i_valid), .i_word(i_word), .i_stack_pointer(i_stack_pointer),
   .i_mem_rdata(i_mem_rdata), .o_regs(o_regs), .o_mem(o_mem), .o_mem_en(o_mem_en),
   .o_skip(o_skip), .o_carry_we(o_carry_we));

// file: dv/register_ram_transfer_exec_test.sv
module register_ram_transfer_exec_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk, i_rstn, i_valid, o_mem_en, o_skip, o_carry_we;
   logic [9:0] i_word;
   logic [2:0] i_stack_pointer;
   logic [3:0] i_mem_rdata;
   rrt_pkg::rrt_regs_t o_regs;
   rrt_pkg::rrt_mem_t o_mem;
   int err_total = 0;
   int tests_run = 0;
   rrt_exec rrt_exec_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(i_valid),
      .i_word(i_word), .i_stack_pointer(i_stack_pointer), .i_mem_rdata(i_mem_rdata),
      .o_regs(o_regs), .o_mem(o_mem), .o_mem_en(o_mem_en), .o_skip(o_skip),
      .o_carry_we(o_carry_we));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // ==================================================================
   // shared tasks
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // called at a falling edge; valid stays up so words run back to back
   task op(input logic [9:0] w, input logic [3:0] rd);
      i_valid = 1'b1;
      i_word = w;
      i_mem_rdata = rd;
      @(negedge i_clk);
   endtask
   task memw(input logic [5:0] p, input logic [3:0] j, input logic [3:0] rd, input logic [3:0] wd,
             input logic [9:0] a);
      i_valid = 1'b1;
      i_word = {p, j};
      i_mem_rdata = rd;
      #1;
      chk("mem_z", o_mem.z, a[9:8]);
      chk("mem_xy", {o_mem.x, o_mem.y}, a[7:0]);
      chk("mem_en", o_mem_en, 8'h01);
      chk("wr", o_mem.wr, 8'h01);
      chk("wdata", o_mem.wdata, wd);
      @(negedge i_clk);
   endtask
   task close_out;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ==================================================================
   // scenarios
   task t_xfer;
      op(10'h339, 4'h0);
      chk("x", o_regs.x, 8'h03);
      chk("y", o_regs.y, 8'h09);
      op({rrt_pkg::PFX_LOAD_ACC_FROM_MEM, 4'h5}, 4'hC);
      chk("acc", o_regs.acc, 8'h0C);
      chk("x", o_regs.x, 8'h06);
      op(rrt_pkg::OP_COPY_ACC_TO_B, 4'h0);
      chk("b", o_regs.b, 8'h0C);
      i_word = {rrt_pkg::PFX_LOAD_ACC_FROM_MEM, 4'h0};
      i_mem_rdata = 4'hE;
      #1;
      chk("ld_en", o_mem_en, 8'h01);
      chk("ld_wr", o_mem.wr, 8'h00);
      @(negedge i_clk);
      op(rrt_pkg::OP_PACK_PAIR_INTO_E, 4'h0);
      chk("e", o_regs.e, 8'hCE);
      op(rrt_pkg::OP_COPY_ACC_TO_D, 4'h0);
      chk("d", o_regs.d, 8'h06);
      op(rrt_pkg::OP_COPY_ROW_TO_ACC, 4'h0);
      chk("acc", o_regs.acc, 8'h09);
      op(rrt_pkg::OP_COPY_B_TO_ACC, 4'h0);
      chk("acc", o_regs.acc, 8'h0C);
      op(rrt_pkg::OP_UNPACK_E_INTO_PAIR, 4'h0);
      chk("acc", o_regs.acc, 8'h0E);
      op(rrt_pkg::OP_COPY_COLUMN_TO_ACC, 4'h0);
      chk("acc", o_regs.acc, 8'h06);
      i_stack_pointer = 3'h5;
      op(rrt_pkg::OP_READ_STACK_POINTER, 4'h0);
      chk("acc", o_regs.acc, 8'h05);
      op(rrt_pkg::OP_COPY_ACC_TO_ROW, 4'h0);
      chk("y", o_regs.y, 8'h05);
      op({rrt_pkg::PFX_LOAD_FILE_GROUP, 2'h2}, 4'h0);
      chk("z", o_regs.z, 8'h02);
   endtask
   task t_mem;
      memw(rrt_pkg::PFX_STORE_ACC_TO_MEM, 4'hF, 4'h0, 4'h5, 10'h265);
      chk("x", o_regs.x, 8'h09);
      memw(rrt_pkg::PFX_SWAP_ACC_MEM, 4'h1, 4'h3, 4'h5, 10'h295);
      chk("acc", o_regs.acc, 8'h03);
      chk("x", o_regs.x, 8'h08);
      memw(rrt_pkg::PFX_SWAP_ACC_MEM_DEC, 4'h0, 4'hA, 4'h3, 10'h285);
      chk("y", o_regs.y, 8'h04);
      chk("skip", o_skip, 8'h00);
      op(10'h30F, 4'h0);
      memw(rrt_pkg::PFX_SWAP_ACC_MEM_INC, 4'h2, 4'h1, 4'hA, 10'h20F);
      chk("acc", o_regs.acc, 8'h01);
      chk("x", o_regs.x, 8'h02);
      chk("y", o_regs.y, 8'h00);
      chk("skip", o_skip, 8'h01);
      op(rrt_pkg::OP_COPY_ACC_TO_B, 4'h0);
      chk("b", o_regs.b, 8'h0C);
      chk("skip", o_skip, 8'h00);
   endtask
   task t_row;
      op(rrt_pkg::OP_ROW_DECREMENT, 4'h0);
      chk("skip", o_skip, 8'h01);
      op(rrt_pkg::OP_COPY_ACC_TO_ROW, 4'h0);
      chk("y", o_regs.y, 8'h0F);
      op(rrt_pkg::OP_ROW_DECREMENT, 4'h0);
      chk("y", o_regs.y, 8'h0E);
      op(rrt_pkg::OP_ROW_INCREMENT, 4'h0);
      chk("skip", o_skip, 8'h00);
   endtask
   task t_run;
      op(10'h312, 4'h0);
      op(10'h334, 4'h0);
      op(10'h356, 4'h0);
      chk("x", o_regs.x, 8'h01);
      chk("y", o_regs.y, 8'h02);
      op(rrt_pkg::OP_COPY_ACC_TO_B, 4'h0);
      op(10'h334, 4'h0);
      chk("x", o_regs.x, 8'h03);
   endtask
   initial begin
      #(1000 * 8);
      err_total++;
      close_out();
   end
   initial begin
      i_rstn = 1'b0;
      i_valid = 1'b0;
      i_word = 10'h000;
      i_stack_pointer = 3'h0;
      i_mem_rdata = 4'h0;
      repeat (6) @(negedge i_clk);
      i_rstn = 1'b1;
      t_xfer();
      t_mem();
      t_row();
      t_run();
      i_valid = 1'b0;
      close_out();
   end
endmodule
